// ---- verilog/safe_stop_pkg.sv ----
// Constants, types and register map of the safe stop timing monitor
package safe_stop_pkg;
  // Clock and time units
  localparam int CLK_PERIOD_NS      = 50;      // pclk period at 20 MHz
  localparam int STOP_DELAY_UNIT_NS = 10_000;  // Stop delay LSB is 0.01 ms
  localparam int TRANS_UNIT_NS      = 10;      // Transition time LSB is 0.01 us
  // Limits of the settable times
  localparam logic [31:0] STOP_DELAY_MAX = 32'h01C9_C380; // 300000.00 ms
  localparam logic [31:0] TRANS_MAX      = 32'hB2D0_5E00; // 30 000 000.00 us
  localparam logic [31:0] TIME_RESET     = 32'h0000_0000;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DELAY    = 8'h04;
  localparam logic [7:0] ADDR_TRANS    = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_CAP      = 8'h18;
  localparam logic [7:0] ADDR_VER0     = 8'h1C;
  localparam logic [7:0] ADDR_VER1     = 8'h20;
  localparam logic [7:0] ADDR_VER2     = 8'h24;
  // Field positions
  localparam int CTRL_ACK_BIT = 0;   // Write 1 to leave the halt state
  localparam int CAP_STO_BIT  = 0;
  localparam int CAP_SBC_BIT  = 1;
  localparam int CAP_MOT_BIT  = 2;
  localparam int CAP_SS1_BIT  = 3;
  localparam int IRQ_W        = 4;
  localparam int EV_BRAKE     = 0;   // Controlled stop started
  localparam int EV_PULSE_OFF = 1;   // Pulses cancelled after delay
  localparam int EV_DEFECT    = 2;   // Channel-defect stop raised
  localparam int EV_HALT      = 3;   // Immediate stop entered
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  typedef enum logic [2:0] {
    st_run, st_braking, st_pulses_off, st_defect, st_halt
  } stop_state_e;

  // Commands to the power stage
  typedef struct packed {
    logic quick_stop_ramp;   // Brake along the quick-stop ramp
    logic pulse_enable;      // Normal control path pulse enable
    logic safety_shutdown;   // Dedicated safety shutdown path
  } drive_cmd_s;

  // Comparison data from the redundant channel
  typedef struct packed {
    logic        valid;
    logic [31:0] stop_delay;
    logic [31:0] transition_time;
  } peer_data_s;
endpackage : safe_stop_pkg

// ---- verilog/safe_stop_timing_monitor.sv ----
// Safe stop timing monitor with APB registers and cross-channel compare
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Function
// - A controlled stop request brakes on the quick-stop ramp and cancels pulses after the stop delay.
// - A stop delay difference to the peer channel of up to one monitoring cycle is not an error.
// - Stop delay and transition time are rounded to whole monitoring cycles before timing.
// - A channel-defect stop escalates to the immediate stop after the transition time.
// - A transition time difference to the peer channel of up to one monitoring cycle is tolerated.
// - A comparison difference beyond tolerance enters the channel-defect stop.
// - The immediate stop removes pulses over the dedicated safety shutdown path.
// - The capability word holds safe torque, brake, motion and controlled stop flags in bits 0 to 3.
// - The capability word is 32 bits, derived here and read-only.
// - Three read-only 16-bit version words are exposed.
module safe_stop_timing_monitor
  import safe_stop_pkg::*;
#(
  parameter int          MON_PERIOD_NS = 1_000_000, // Monitoring cycle
  parameter logic        CAP_STO       = 1'b1,      // Terminal safe torque removal
  parameter logic        CAP_SBC       = 1'b1,      // Safe brake control
  parameter logic        CAP_SS1       = 1'b1,      // Controlled safe stop
  parameter logic [15:0] VERSION0      = 16'h0001,  // Arbitrary value
  parameter logic [15:0] VERSION1      = 16'h0002,  // Arbitrary value
  parameter logic [15:0] VERSION2      = 16'h0003   // Arbitrary value
)(
  input  wire logic        pclk,                // Clock
  input  wire logic        presetn,             // Async reset, low
  input  wire logic        ce,                  // Clock enable
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB enable
  input  wire logic        pwrite,              // APB write
  input  wire logic [7:0]  paddr,               // APB address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  input  wire logic        stop_req_pin,        // Controlled stop request pin
  input  wire logic        cu_motion_supported, // Control unit motion flag
  input  wire peer_data_s  peer,                // Redundant channel data
  output drive_cmd_s       drive,               // Power stage commands
  output logic             irq                  // Interrupt, high level
);
  localparam int          MON_CLKS  = MON_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [31:0] TICK_LAST = 32'(MON_CLKS - 1);
  localparam logic [32:0] CYC_D     = 33'(MON_PERIOD_NS / STOP_DELAY_UNIT_NS);
  localparam logic [32:0] CYC_T     = 33'(MON_PERIOD_NS / TRANS_UNIT_NS);

  logic        [31:0]      tick_cnt;
  logic                    stop_meta;
  logic                    stop_s;
  stop_state_e             state;
  stop_state_e             next_state;
  logic        [32:0]      remaining;
  logic        [32:0]      next_remaining;
  logic        [31:0]      stop_delay;
  logic        [31:0]      trans_time;
  logic        [IRQ_W-1:0] irq_status;
  logic        [IRQ_W-1:0] irq_mask;

  // Monitoring cycle tick
  wire tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
    end else if (ce) begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // Stop request pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_meta <= 1'b0;
      stop_s    <= 1'b0;
    end else if (ce) begin
      stop_meta <= stop_req_pin;
      stop_s    <= stop_meta;
    end
  end

  // Cross comparison against the peer channel, one cycle tolerated
  wire [32:0] own_d  = {1'b0, stop_delay};
  wire [32:0] own_t  = {1'b0, trans_time};
  wire [32:0] peer_d = {1'b0, peer.stop_delay};
  wire [32:0] peer_t = {1'b0, peer.transition_time};
  wire [32:0] diff_d = (own_d >= peer_d) ? own_d - peer_d : peer_d - own_d;
  wire [32:0] diff_t = (own_t >= peer_t) ? own_t - peer_t : peer_t - own_t;
  wire        bad_d  = diff_d > CYC_D;
  wire        bad_t  = diff_t > CYC_T;
  wire        mismatch = peer.valid && (bad_d || bad_t);

  // APB decode
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready;
  wire wr       = access && pwrite;
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_dly  = (paddr == ADDR_DELAY);
  wire sel_trn  = (paddr == ADDR_TRANS);
  wire sel_st   = (paddr == ADDR_STATUS);
  wire sel_ist  = (paddr == ADDR_IRQ_STAT);
  wire sel_imk  = (paddr == ADDR_IRQ_MASK);
  wire sel_cap  = (paddr == ADDR_CAP);
  wire sel_v0   = (paddr == ADDR_VER0);
  wire sel_v1   = (paddr == ADDR_VER1);
  wire sel_v2   = (paddr == ADDR_VER2);
  wire mapped   = sel_ctrl || sel_dly || sel_trn || sel_st || sel_ist
                  || sel_imk || sel_cap || sel_v0 || sel_v1 || sel_v2;
  wire ack      = wr && sel_ctrl && pwdata[CTRL_ACK_BIT];
  wire rd_clear = access && !pwrite && sel_ist;

  // Capability word derived from own and control unit support
  wire [31:0] cap_word = {28'h000_0000, CAP_SS1, cu_motion_supported,
                          CAP_SBC, CAP_STO};

  // Read data selection; capability and versions are read-only
  wire [31:0] rdata =
      sel_ctrl ? 32'h0000_0000 :
      sel_dly  ? stop_delay :
      sel_trn  ? trans_time :
      sel_st   ? {29'h0000_0000, state} :
      sel_ist  ? {28'h000_0000, irq_status} :
      sel_imk  ? {28'h000_0000, irq_mask} :
      sel_cap  ? cap_word :
      sel_v0   ? {16'h0000, VERSION0} :
      sel_v1   ? {16'h0000, VERSION1} :
      sel_v2   ? {16'h0000, VERSION2} : 32'h0000_0000;

  // Timer: rounded load, expires below one monitoring cycle
  wire [32:0] cyc_now   = (state == st_defect) ? CYC_T : CYC_D;
  wire        expired   = remaining < cyc_now;
  wire        timing    = (state == st_braking) || (state == st_defect);
  wire [32:0] load_d    = own_d + (CYC_D >> 1);
  wire [32:0] load_t    = own_t + (CYC_T >> 1);
  wire        enter_brk = (next_state == st_braking) && (state != st_braking);
  wire        enter_def = (next_state == st_defect) && (state != st_defect);

  // Stop sequencing
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (mismatch) next_state = st_defect;
        else if (stop_s) next_state = st_braking;
      end
      st_braking: begin
        if (mismatch) next_state = st_defect;
        else if (!stop_s) next_state = st_run;
        else if (expired) next_state = st_pulses_off;
      end
      st_pulses_off: begin
        if (mismatch) next_state = st_defect;
        else if (!stop_s) next_state = st_run;
      end
      st_defect: begin
        if (expired) next_state = st_halt;
      end
      st_halt: begin
        if (ack) next_state = st_run;
      end
      default: next_state = st_run;
    endcase
  end

  // Remaining time, counted down once per monitoring cycle
  always_comb begin
    next_remaining = remaining;
    if (enter_brk) next_remaining = load_d;
    else if (enter_def) next_remaining = load_t;
    else if (timing && tick && !expired) next_remaining = remaining - cyc_now;
  end

  // Events and read-to-clear status, a new event beats the clear
  wire [IRQ_W-1:0] events = {
    enter_def ? 1'b0 : (next_state == st_halt) && (state != st_halt),
    enter_def,
    (next_state == st_pulses_off) && (state != st_pulses_off),
    enter_brk};
  wire [IRQ_W-1:0] next_irq_status =
      (rd_clear ? IRQ_RESET : irq_status) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_run;
      remaining  <= 33'h0_0000_0000;
      irq_status <= IRQ_RESET;
      irq        <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      remaining  <= next_remaining;
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Power stage commands follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else if (ce) begin
      drive.quick_stop_ramp <= (next_state == st_braking);
      drive.pulse_enable    <= (next_state == st_run) || (next_state == st_braking)
                               || (next_state == st_defect);
      drive.safety_shutdown <= (next_state == st_halt);
    end
  end

  // Configuration registers, times clamped to their limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_delay <= TIME_RESET;
      trans_time <= TIME_RESET;
      irq_mask   <= IRQ_RESET;
    end else if (ce && wr) begin
      if (sel_dly) stop_delay <= (pwdata > STOP_DELAY_MAX) ? STOP_DELAY_MAX : pwdata;
      if (sel_trn) trans_time <= (pwdata > TRANS_MAX) ? TRANS_MAX : pwdata;
      if (sel_imk) irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      prdata  <= setup ? rdata : prdata;
      pslverr <= setup && !mapped;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BRAKE_TO_PULSE_OFF: assert property (
    ce && state == st_braking && stop_s && !mismatch && expired
    |=> state == st_pulses_off && !drive.pulse_enable)
    else $error("Pulses not cancelled after stop delay");
  AST_RAMP_WHILE_BRAKING: assert property (
    ce && next_state == st_braking |=> drive.quick_stop_ramp && drive.pulse_enable)
    else $error("Quick-stop ramp not commanded while braking");
  AST_DELAY_TOLERANCE: assert property (
    ce && peer.valid && diff_d <= CYC_D && !bad_t && state == st_run |=> state != st_defect)
    else $error("Stop delay within one cycle flagged as defect");
  AST_ROUNDED_LOAD: assert property (
    ce && state == st_run && next_state == st_braking
    |=> remaining == $past(own_d) + (CYC_D >> 1))
    else $error("Stop delay not loaded with rounding");
  AST_ESCALATE: assert property (
    ce && state == st_defect && expired |=> state == st_halt ##0 drive.safety_shutdown)
    else $error("Defect stop did not escalate");
  AST_TRANS_TOLERANCE: assert property (
    ce && peer.valid && diff_t <= CYC_T && !bad_d && state == st_run |=> state != st_defect)
    else $error("Transition time within one cycle flagged as defect");
  AST_DEFECT_ON_MISMATCH: assert property (
    ce && mismatch && state != st_defect && state != st_halt |=> state == st_defect)
    else $error("Mismatch did not raise defect stop");
  AST_HALT_SHUTDOWN: assert property (
    state == st_halt |-> drive.safety_shutdown && !drive.pulse_enable)
    else $error("Immediate stop not on safety shutdown path");
  AST_CAP_WORD: assert property (
    ce && setup && sel_cap |=> prdata[31:4] == 28'h000_0000 && prdata[CAP_SS1_BIT] == CAP_SS1)
    else $error("Capability word layout wrong");
  AST_CAP_RO: assert property (
    wr && sel_cap |=> $stable(cap_word))
    else $error("Capability word changed by write");
  AST_VERSION_READ: assert property (
    ce && setup && sel_v1 |=> prdata == {16'h0000, VERSION1})
    else $error("Version word read wrong");
  AST_COUNTDOWN: assert property (
    ce && timing && tick && !expired && next_state == state
    |=> remaining == $past(remaining) - $past(cyc_now))
    else $error("Timer did not fall by one monitoring cycle");
endmodule : safe_stop_timing_monitor

// ---- verification/peer_channel_model.sv ----
// Model of the redundant monitoring channel that feeds comparison data
`timescale 1ns/100ps
module peer_channel_model
  import safe_stop_pkg::*;
(
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Async reset, low
  input  wire logic        enable,     // Publish comparison data
  input  wire logic [31:0] delay_copy, // Peer stop delay copy
  input  wire logic [31:0] trans_copy, // Peer transition time copy
  output peer_data_s       peer        // Data towards the device
);
  // Publish copies each cycle; when idle, show inverted data so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peer <= '0;
    end else if (enable) begin
      peer <= {1'b1, delay_copy, trans_copy};
    end else begin
      peer <= {1'b0, ~peer.stop_delay, ~peer.transition_time};
    end
  end
endmodule : peer_channel_model

// ---- verification/safe_stop_timing_monitor_bench.sv ----
// Self-checking bench for the safe stop timing monitor
`timescale 1ns/100ps
module safe_stop_timing_monitor_bench;
  import safe_stop_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stop_req_pin, cu_mot, peer_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, p_delay, p_trans;
  logic        pready, pslverr, irq;
  peer_data_s  peer;
  drive_cmd_s  drive;
  int          error_cnt, n_checks;
  // Expected drive commands: ramp, pulse enable, shutdown
  localparam logic [2:0] D_RUN = 3'b010, D_BRAKE = 3'b110, D_OFF = 3'b000, D_HALT = 3'b001;

  safe_stop_timing_monitor #(.MON_PERIOD_NS(20000)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_req_pin(stop_req_pin), .cu_motion_supported(cu_mot),
    .peer(peer), .drive(drive), .irq(irq));
  peer_channel_model u_peer (.pclk(pclk), .presetn(presetn), .enable(peer_en),
    .delay_copy(p_delay), .trans_copy(p_trans), .peer(peer));

  // Clock at 20 MHz
  always #25 pclk = ~pclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer: setup, access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp,
                    input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(what, exp, r);
    chk("pslverr", {31'h0, eexp}, {31'h0, e});
  endtask : rd

  // Wait for a drive command, counting clocks, then compare it
  task automatic wait_drive(input logic [2:0] want, input int lim, output int n);
    n = 0;
    while (drive !== want && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("drive", {29'h0, want}, {29'h0, drive});
  endtask : wait_drive

  // Reset values, read-only words, unmapped access
  task automatic test_regs();
    rd("delay", ADDR_DELAY, TIME_RESET, 1'b0);
    rd("trans", ADDR_TRANS, TIME_RESET, 1'b0);
    rd("cap", ADDR_CAP, 32'h0000_000F, 1'b0);
    cu_mot <= 1'b0;
    wr(ADDR_CAP, 32'hFFFF_FFFF);
    rd("cap", ADDR_CAP, 32'h0000_000B, 1'b0);
    rd("ver0", ADDR_VER0, 32'h0000_0001, 1'b0);
    wr(ADDR_VER1, 32'h0000_FFFF);
    rd("ver1", ADDR_VER1, 32'h0000_0002, 1'b0);
    rd("ver2", ADDR_VER2, 32'h0000_0003, 1'b0);
    rd("unmapped", 8'h40, 32'h0000_0000, 1'b1);
    // One and a half monitoring cycles each, so rounding decides the span
    wr(ADDR_DELAY, 32'h0000_0003);
    wr(ADDR_TRANS, 32'h0000_0BB8);
    rd("delay", ADDR_DELAY, 32'h0000_0003, 1'b0);
    rd("trans", ADDR_TRANS, 32'h0000_0BB8, 1'b0);
  endtask : test_regs

  // Controlled stop: ramp at once, pulses off after two rounded monitoring cycles
  task automatic test_stop();
    int n;
    wr(ADDR_IRQ_MASK, 32'h0000_000F);
    p_delay <= 32'h0000_0003;
    p_trans <= 32'h0000_0BB8;
    peer_en <= 1'b1;
    stop_req_pin <= 1'b1;
    wait_drive(D_BRAKE, 8, n);
    chk("brake latency", 32'h1, {31'h0, n <= 5});
    wait_drive(D_OFF, 900, n);
    chk("delay span", 32'h1, {31'h0, n >= 402 && n <= 801});
    chk("irq", 32'h1, {31'h0, irq});
    rd("irq stat", ADDR_IRQ_STAT, 32'h0000_0003, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    stop_req_pin <= 1'b0;
    wait_drive(D_RUN, 10, n);
  endtask : test_stop

  // Cross compare: one cycle tolerated, more starts defect and later halt
  task automatic test_cross();
    int n;
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    p_delay <= 32'h0000_0005;
    p_trans <= 32'h0000_1388;
    repeat (20) @(posedge pclk);
    rd("state", ADDR_STATUS, 32'h0000_0000, 1'b0);
    p_delay <= 32'h0000_0006;
    repeat (6) @(posedge pclk);
    rd("state", ADDR_STATUS, 32'h0000_0003, 1'b0);
    chk("drive", {29'h0, D_RUN}, {29'h0, drive});
    wait_drive(D_HALT, 900, n);
    chk("halt span", 32'h1, {31'h0, n >= 396 && n <= 795});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd("irq stat", ADDR_IRQ_STAT, 32'h0000_000C, 1'b0);
    p_delay <= 32'h0000_0003;
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_drive(D_RUN, 10, n);
    rd("state", ADDR_STATUS, 32'h0000_0000, 1'b0);
  endtask : test_cross

  // Main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; stop_req_pin = 1'b0; cu_mot = 1'b1;
    peer_en = 1'b0; p_delay = 32'h0000_0000; p_trans = 32'h0000_0000;
    error_cnt = 0; n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_stop();
    test_cross();
    test_done();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    test_done();
  end
endmodule : safe_stop_timing_monitor_bench
